// [common/vshc_pkg.sv]
// Shared constants, encodings and carrier types for the vehicle speed hold controller
package vshc_pkg;

	// ==========================================================
	// Clock and oscillator rates
	localparam int unsigned CLK_FREQ_HZ = 40000000;
	localparam int unsigned MAIN_OSC_FREQ_HZ = 1680;
	localparam int unsigned PULSE_OSC_FREQ_HZ = 1600;
	localparam int unsigned MAIN_DIV = CLK_FREQ_HZ / MAIN_OSC_FREQ_HZ;
	localparam int unsigned PULSE_DIV = CLK_FREQ_HZ / PULSE_OSC_FREQ_HZ;
	localparam int DIV_W = 16;

	// ==========================================================
	// Control cycle, in master oscillator periods
	localparam int SAMPLE_TICKS = 1008;
	localparam int PROC_TICKS = 16;
	localparam int OUT_DELAY_TICKS = 9;
	localparam int HOLD_TICKS = 16;
	localparam logic [9:0] WIN_END = 10'(SAMPLE_TICKS);
	localparam logic [9:0] WIN_LAST = 10'(SAMPLE_TICKS - 1);
	localparam logic [9:0] OUT_POS = 10'(SAMPLE_TICKS - 1 + OUT_DELAY_TICKS);
	localparam logic [9:0] CYC_LAST = 10'(SAMPLE_TICKS + PROC_TICKS - 1);
	localparam logic [4:0] QUAL_TICKS = 5'(HOLD_TICKS);

	// ==========================================================
	// Speed scale: half pulses per sampling window
	localparam int SPD_W = 10;
	localparam logic [9:0] MIN_SPEED = 10'(2 * SAMPLE_TICKS * 2 / 63);
	localparam logic [9:0] MAX_SPEED = 10'(2 * SAMPLE_TICKS * 5 / 42);
	localparam logic [9:0] RB_DROP = 10'(2 * SAMPLE_TICKS / 63);
	localparam logic [9:0] SPEED_UP_COMMAND_STEP = 10'h003;
	localparam logic [9:0] SPEED_RST = 10'h000;
	localparam logic [9:0] SPEED_SAT = 10'h3FF;

	// ==========================================================
	// Encodings
	typedef enum logic [2:0] {
		MODE_OFF = 3'b000,
		MODE_HOLD = 3'b001,
		MODE_SPEED_UP = 3'b010,
		MODE_COAST = 3'b011,
		MODE_RETURN = 3'b100
	} vshc_mode_t;

	// Bit 1 drives the apply valve, bit 0 the release valve
	typedef enum logic [1:0] {
		VALVE_DEC = 2'b00,
		VALVE_HOLD = 2'b01,
		VALVE_INC = 2'b11
	} vshc_valve_t;

	typedef struct packed {
		logic pedal;
		logic ret;
		logic speed_up;
		logic coast;
	} vshc_cmd_t;

	localparam vshc_cmd_t CMD_RST = 4'h0;

endpackage : vshc_pkg

// [hw/vshc_tick_div.sv]
// Free-running divider giving one-cycle ticks that stand in for an oscillator
`timescale 1ns/100ps
module vshc_tick_div
	import vshc_pkg::*;
#(
	parameter int unsigned DIV = 2
) (
	input wire logic clock,
	input wire logic rst,
	output logic tick
);

	logic [DIV_W-1:0] cnt_reg;
	wire wrap = (cnt_reg == DIV_W'(DIV - 1));

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			tick <= 1'b0;
		end else begin
			cnt_reg <= wrap ? '0 : cnt_reg + DIV_W'(1);
			tick <= wrap;
		end
	end

endmodule : vshc_tick_div

// [hw/vshc_speed_hold.sv]
// Speed hold controller: speed sampling, mode control and valve drive
`timescale 1ns/100ps
module vshc_speed_hold
	import vshc_pkg::*;
#(
	parameter int unsigned MAIN_DIV_P = MAIN_DIV,
	parameter int unsigned PULSE_DIV_P = PULSE_DIV
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic wheel_pulse_in,
	input wire logic coast_cmd_in,
	input wire logic speed_up_cmd_in,
	input wire logic return_to_set_cmd_in,
	input wire logic pedal_disable_in,
	output logic throttle_apply_out,
	output logic throttle_release_out
);

	// ==========================================================
	// Time bases
	logic main_tick;
	logic pulse_tick;
	vshc_tick_div #(.DIV(MAIN_DIV_P)) u_main_osc (
		.clock(clock),
		.rst(rst),
		.tick(main_tick)
	);
	// Trim width comes from its own time base so it can be tuned to the servo
	vshc_tick_div #(.DIV(PULSE_DIV_P)) u_pulse_osc (
		.clock(clock),
		.rst(rst),
		.tick(pulse_tick)
	);

	// ==========================================================
	// Input synchronisers
	vshc_cmd_t cmd_meta_reg;
	vshc_cmd_t cmd_sync_reg;
	vshc_cmd_t cmd_prev_reg;
	logic wheel_meta_reg;
	logic wheel_sync_reg;
	logic wheel_prev_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmd_meta_reg <= CMD_RST;
			cmd_sync_reg <= CMD_RST;
			cmd_prev_reg <= CMD_RST;
			wheel_meta_reg <= 1'b0;
			wheel_sync_reg <= 1'b0;
			wheel_prev_reg <= 1'b0;
		end else begin
			cmd_meta_reg <= {pedal_disable_in, return_to_set_cmd_in,
				speed_up_cmd_in, coast_cmd_in};
			cmd_sync_reg <= cmd_meta_reg;
			cmd_prev_reg <= cmd_sync_reg;
			wheel_meta_reg <= wheel_pulse_in;
			wheel_sync_reg <= wheel_meta_reg;
			wheel_prev_reg <= wheel_sync_reg;
		end
	end
	wire brake = cmd_sync_reg.pedal;
	wire resume_rise = cmd_sync_reg.ret & ~cmd_prev_reg.ret;

	// ==========================================================
	// Hold qualifiers: short taps on speed-up or coast are ignored
	wire [1:0] hold_lvl = {cmd_sync_reg.coast, cmd_sync_reg.speed_up};
	logic [1:0] qual;
	for (genvar g = 0; g < 2; g++) begin : g_qual
		logic [4:0] cnt_reg;
		wire [4:0] cnt_next = !hold_lvl[g] ? 5'h00 :
			(main_tick && !qual[g]) ? cnt_reg + 5'h01 : cnt_reg;
		assign qual[g] = (cnt_reg == QUAL_TICKS);
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				cnt_reg <= 5'h00;
			end else begin
				cnt_reg <= cnt_next;
			end
		end
	end
	wire up_q = qual[0];
	wire coast_q = qual[1];

	// ==========================================================
	// Control cycle and speed sampling
	logic [9:0] cyc_reg;
	logic [SPD_W-1:0] edge_cnt_reg;
	logic [SPD_W-1:0] sample_reg;
	wire decide = main_tick && (cyc_reg == WIN_LAST);
	wire out_step = main_tick && (cyc_reg == OUT_POS);
	wire in_window = (cyc_reg < WIN_END);
	wire wheel_edge = wheel_sync_reg ^ wheel_prev_reg;
	wire [9:0] cyc_next = !main_tick ? cyc_reg :
		(cyc_reg == CYC_LAST) ? 10'h000 : cyc_reg + 10'h001;
	// Both edges count, so one unit is half a sensor period
	wire [SPD_W-1:0] edge_cnt_next = decide ? SPEED_RST :
		(in_window && wheel_edge && edge_cnt_reg != SPEED_SAT) ?
		edge_cnt_reg + 10'h001 : edge_cnt_reg;
	wire [SPD_W-1:0] sample_next = decide ? edge_cnt_reg : sample_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cyc_reg <= 10'h000;
			edge_cnt_reg <= SPEED_RST;
			sample_reg <= SPEED_RST;
		end else begin
			cyc_reg <= cyc_next;
			edge_cnt_reg <= edge_cnt_next;
			sample_reg <= sample_next;
		end
	end

	// ==========================================================
	// Mode control
	vshc_mode_t mode_reg;
	vshc_mode_t mode_next;
	vshc_valve_t dec_reg;
	vshc_valve_t dec_next;
	logic [SPD_W-1:0] ref_reg;
	logic [SPD_W-1:0] ref_next;
	logic ref_valid_reg;
	logic ref_valid_next;
	wire [SPD_W-1:0] new_speed = edge_cnt_reg;
	wire in_range = (sample_reg >= MIN_SPEED) && (sample_reg <= MAX_SPEED);
	wire below_min = (new_speed < MIN_SPEED);
	wire rb_trip = ref_valid_reg &&
		((11'(new_speed) + 11'(RB_DROP)) <= 11'(ref_reg));
	wire speed_up_command_slow = 11'(new_speed) < (11'(sample_reg) + 11'(SPEED_UP_COMMAND_STEP));
	wire at_ref = (new_speed >= ref_reg);
	wire vshc_valve_t speed_up_command_cmd = speed_up_command_slow ? VALVE_INC : VALVE_HOLD;
	wire vshc_valve_t trim_cmd = (new_speed < ref_reg) ? VALVE_INC :
		(new_speed > ref_reg) ? VALVE_DEC : VALVE_HOLD;
	wire cmd_free = !brake && !coast_q && !up_q;
	wire resume_take = resume_rise && ref_valid_reg && (mode_reg != MODE_RETURN);

	always_comb begin
		mode_next = mode_reg;
		dec_next = dec_reg;
		ref_next = ref_reg;
		ref_valid_next = ref_valid_reg;
		if (brake) begin
			mode_next = MODE_OFF;
		end else if (coast_q) begin
			mode_next = MODE_COAST;
		end else if (up_q) begin
			mode_next = MODE_SPEED_UP;
			if (decide) begin
				dec_next = speed_up_command_cmd;
			end else if (mode_reg != MODE_SPEED_UP) begin
				dec_next = VALVE_INC;
			end
		end else if (resume_take) begin
			mode_next = MODE_RETURN;
			dec_next = VALVE_INC;
		end else begin
			unique case (mode_reg)
				MODE_OFF: begin
					mode_next = MODE_OFF;
				end
				MODE_COAST, MODE_SPEED_UP: begin
					// Out-of-range speeds keep the old reference
					if (in_range) begin
						ref_next = sample_reg;
						ref_valid_next = 1'b1;
					end
					mode_next = (in_range || ref_valid_reg) ? MODE_HOLD : MODE_OFF;
					dec_next = VALVE_HOLD;
				end
				MODE_HOLD: begin
					if (decide) begin
						if (below_min || rb_trip) begin
							mode_next = MODE_OFF;
						end else begin
							dec_next = trim_cmd;
						end
					end
				end
				MODE_RETURN: begin
					if (decide) begin
						if (rb_trip) begin
							mode_next = MODE_OFF;
						end else if (at_ref) begin
							mode_next = MODE_HOLD;
							dec_next = VALVE_HOLD;
						end else begin
							dec_next = speed_up_command_cmd;
						end
					end
				end
				default: begin
					mode_next = MODE_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_reg <= MODE_OFF;
			dec_reg <= VALVE_HOLD;
			ref_reg <= SPEED_RST;
			ref_valid_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			dec_reg <= dec_next;
			ref_reg <= ref_next;
			ref_valid_reg <= ref_valid_next;
		end
	end

	// ==========================================================
	// Valve drive
	vshc_valve_t valve_reg;
	wire hold_like = (mode_reg == MODE_HOLD) || (mode_reg == MODE_SPEED_UP) ||
		(mode_reg == MODE_RETURN);
	// A trim pulse ends at the next pulse tick, so it never exceeds one period
	wire vshc_valve_t valve_next = !hold_like ? VALVE_DEC :
		out_step ? dec_reg :
		pulse_tick ? VALVE_HOLD : valve_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			valve_reg <= VALVE_DEC;
		end else begin
			valve_reg <= valve_next;
		end
	end

	assign throttle_apply_out = valve_reg[1];
	assign throttle_release_out = valve_reg[0];

	// ==========================================================
	// Assertions
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_valves_low;
		!throttle_apply_out && !throttle_release_out;
	endsequence
	sequence s_off_then_low;
		(mode_reg == MODE_OFF) ##1 s_valves_low;
	endsequence
	property p_valve_code;
		!(throttle_apply_out && !throttle_release_out);
	endproperty
	a_valve_code: assert property (p_valve_code) else $error("apply-only valve code");
	property p_coast_low;
		(coast_q && !brake) |-> ##2 s_valves_low;
	endproperty
	a_coast_low: assert property (p_coast_low) else $error("coast did not close valves");
	property p_coast_store;
		(mode_reg == MODE_COAST && cmd_free && !resume_take && in_range)
			|=> (ref_reg == $past(sample_reg)) && ref_valid_reg && mode_reg == MODE_HOLD;
	endproperty
	a_coast_store: assert property (p_coast_store) else $error("coast release not stored");
	property p_up_mod;
		(mode_reg == MODE_SPEED_UP && out_step) |=> throttle_release_out;
	endproperty
	a_up_mod: assert property (p_up_mod) else $error("speed-up drove decrease");
	property p_up_store;
		(mode_reg == MODE_SPEED_UP && cmd_free && !resume_take && in_range)
			|=> (ref_reg == $past(sample_reg)) && ref_valid_reg;
	endproperty
	a_up_store: assert property (p_up_store) else $error("speed-up release not stored");
	property p_return_lock;
		(resume_take && cmd_free) |=> (mode_reg == MODE_RETURN);
	endproperty
	a_return_lock: assert property (p_return_lock) else $error("resume not taken");
	property p_return_end;
		(mode_reg == MODE_RETURN && decide && cmd_free && !rb_trip && at_ref)
			|=> (mode_reg == MODE_HOLD) && (dec_reg == VALVE_HOLD);
	endproperty
	a_return_end: assert property (p_return_end) else $error("resume did not end");
	property p_brake_off;
		brake |-> ##1 s_off_then_low;
	endproperty
	a_brake_off: assert property (p_brake_off) else $error("brake did not disable");
	property p_window_latch;
		decide |=> (sample_reg == $past(edge_cnt_reg)) && (edge_cnt_reg == SPEED_RST);
	endproperty
	a_window_latch: assert property (p_window_latch) else $error("sample not latched");
	property p_proc_idle;
		(cyc_reg >= WIN_END) |-> (edge_cnt_reg == SPEED_RST);
	endproperty
	a_proc_idle: assert property (p_proc_idle) else $error("counting during processing");
	property p_cycle_wrap;
		(main_tick && cyc_reg == CYC_LAST) |=> (cyc_reg == 10'h000);
	endproperty
	a_cycle_wrap: assert property (p_cycle_wrap) else $error("cycle did not wrap");
	property p_out_delay;
		(out_step && hold_like) |=> (valve_reg == $past(dec_reg));
	endproperty
	a_out_delay: assert property (p_out_delay) else $error("valve not updated");
	property p_ref_range;
		ref_valid_reg |-> (ref_reg >= MIN_SPEED) && (ref_reg <= MAX_SPEED);
	endproperty
	a_ref_range: assert property (p_ref_range) else $error("reference out of range");
	property p_redundant;
		(mode_reg == MODE_HOLD && decide && cmd_free && !resume_take && rb_trip)
			|=> (mode_reg == MODE_OFF) ##1 s_valves_low;
	endproperty
	a_redundant: assert property (p_redundant) else $error("speed drop not caught");
	property p_half_count;
		(in_window && wheel_edge && !decide && edge_cnt_reg != SPEED_SAT)
			|=> (edge_cnt_reg == $past(edge_cnt_reg) + 10'h001);
	endproperty
	a_half_count: assert property (p_half_count) else $error("edge not counted");
	property p_trim_end;
		(hold_like && pulse_tick && !out_step)
			|=> throttle_release_out && !throttle_apply_out;
	endproperty
	a_trim_end: assert property (p_trim_end) else $error("trim pulse not ended");

endmodule : vshc_speed_hold

// [tb/vshc_servo_model.sv]
// Throttle servo valve model: watches the valve pair and records what it was commanded
`timescale 1ns/100ps
module vshc_servo_model
	import vshc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic throttle_apply_out,
	input wire logic throttle_release_out,
	input wire logic clear,
	output logic saw_inc,
	output logic saw_dec,
	output logic saw_hold,
	output logic [7:0] bad_count,
	output logic [15:0] inc_run_max,
	output logic [15:0] inc_gap
);
	// ==========================================================
	// Valve decode
	logic [1:0] code;
	logic [1:0] prev_reg;
	logic [15:0] run_reg;
	logic [15:0] gap_reg;
	logic [15:0] run_next;
	assign code = {throttle_apply_out, throttle_release_out};
	assign run_next = (code == VALVE_INC) ? run_reg + 16'h0001 : 16'h0000;

	// ==========================================================
	// Recording; flags are sticky until the bench clears them
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			saw_inc <= 1'h0;
			saw_dec <= 1'h0;
			saw_hold <= 1'h0;
			bad_count <= 8'h00;
			inc_run_max <= 16'h0000;
			inc_gap <= 16'h0000;
			prev_reg <= 2'h0;
			run_reg <= 16'h0000;
			gap_reg <= 16'h0000;
		end else begin
			prev_reg <= code;
			run_reg <= run_next;
			gap_reg <= gap_reg + 16'h0001;
			if (clear) begin
				saw_inc <= 1'h0;
				saw_dec <= 1'h0;
				saw_hold <= 1'h0;
				inc_run_max <= 16'h0000;
			end else begin
				saw_inc <= saw_inc | (code == VALVE_INC);
				saw_dec <= saw_dec | (code == VALVE_DEC);
				saw_hold <= saw_hold | (code == VALVE_HOLD);
				if (run_next > inc_run_max) inc_run_max <= run_next;
			end
			if (code == 2'h2) bad_count <= bad_count + 8'h01;
			if (code == VALVE_INC && prev_reg != VALVE_INC) begin
				inc_gap <= gap_reg;
				gap_reg <= 16'h0001;
			end
		end
	end
endmodule : vshc_servo_model

// [tb/tb.sv]
// Self-checking bench for the speed hold controller
`timescale 1ns/100ps
module tb
	import vshc_pkg::*;
;
	// ==========================================================
	// Shortened time base keeps the run short
	localparam int MD = 4;
	localparam int PD = 37;
	localparam int CYC = 1024 * MD;
	typedef struct {int half; logic inc; logic dec; logic [1:0] fin;} vshc_row_t;
	logic clock, rst, wheel, coast, spd_up, ret, pedal, clear;
	logic apply_w, release_w, saw_inc, saw_dec, saw_hold;
	logic [7:0] bad_count;
	logic [15:0] inc_run_max, inc_gap;
	int half = 30, err_count, n_checks;
	vshc_row_t rows [3] = '{'{32, 1'h1, 1'h0, 2'h1}, '{28, 1'h0, 1'h1, 2'h1},
		'{45, 1'h0, 1'h1, 2'h0}};

	vshc_speed_hold #(.MAIN_DIV_P(MD), .PULSE_DIV_P(PD)) vshc_speed_hold_inst (
		.clock(clock), .rst(rst), .wheel_pulse_in(wheel), .coast_cmd_in(coast),
		.speed_up_cmd_in(spd_up), .return_to_set_cmd_in(ret), .pedal_disable_in(pedal),
		.throttle_apply_out(apply_w), .throttle_release_out(release_w));
	vshc_servo_model vshc_servo_model_inst (.clock(clock), .rst(rst),
		.throttle_apply_out(apply_w), .throttle_release_out(release_w), .clear(clear),
		.saw_inc(saw_inc), .saw_dec(saw_dec), .saw_hold(saw_hold), .bad_count(bad_count),
		.inc_run_max(inc_run_max), .inc_gap(inc_gap));

	// ==========================================================
	// Clock and speed sensor
	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		wheel = 1'h0;
		forever begin
			repeat (half) @(posedge clock);
			#2 wheel = ~wheel;
		end
	end

	// ==========================================================
	// Helpers
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : wait_clk
	task automatic chk_flag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_flag
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic pulse_clear();
		clear = 1'h1;
		wait_clk(1);
		clear = 1'h0;
	endtask : pulse_clear
	// Skip one cycle so only decisions from a clean window are watched
	task automatic step(input vshc_row_t r);
		half = r.half;
		wait_clk(CYC);
		pulse_clear();
		wait_clk(CYC + 100);
	endtask : step
	task automatic chk_row(input vshc_row_t r);
		chk_flag(saw_inc, r.inc);
		chk_flag(saw_dec, r.dec);
		chk_val(16'({apply_w, release_w}), 16'(r.fin));
	endtask : chk_row
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	initial begin
		repeat (95000) @(posedge clock);
		err_count++;
		close_out();
	end

	// ==========================================================
	// Tests
	initial begin
		rst = 1'h1; coast = 1'h0; spd_up = 1'h0; ret = 1'h0; pedal = 1'h0; clear = 1'h0;
		half = 30; err_count = 0; n_checks = 0;
		wait_clk(10);
		rst = 1'h0;
		chk_val(16'({apply_w, release_w}), 16'h0000);
		coast = 1'h1;
		wait_clk(80);
		pulse_clear();
		wait_clk(CYC);
		chk_flag(saw_inc | saw_hold, 1'h0);
		coast = 1'h0;
		$display("test coast held done");
		foreach (rows[i]) begin
			step(rows[i]);
			chk_row(rows[i]);
		end
		$display("test table done");
		half = 30;
		wait_clk(CYC);
		coast = 1'h1;
		wait_clk(80);
		coast = 1'h0;
		wait_clk(CYC);
		pedal = 1'h1;
		wait_clk(5);
		chk_val(16'({apply_w, release_w}), 16'h0000);
		pedal = 1'h0;
		pulse_clear();
		wait_clk(CYC + 100);
		chk_flag(saw_hold | saw_inc, 1'h0);
		$display("test brake done");
		ret = 1'h1;
		wait_clk(50);
		ret = 1'h0;
		step(rows[0]);
		chk_row(rows[0]);
		step(rows[1]);
		chk_row(rows[1]);
		$display("test resume done");
		spd_up = 1'h1;
		step('{36, 1'h1, 1'h0, 2'h1});
		chk_row('{36, 1'h1, 1'h0, 2'h1});
		chk_val(inc_gap, 16'(CYC));
		chk_flag(inc_run_max <= 16'(PD), 1'h1);
		spd_up = 1'h0;
		step(rows[1]);
		chk_row(rows[1]);
		$display("test speed up done");
		step('{80, 1'h0, 1'h1, 2'h0});
		chk_row('{80, 1'h0, 1'h1, 2'h0});
		chk_val(16'(bad_count), 16'h0000);
		$display("test low speed done");
		rst = 1'h1;
		wait_clk(10);
		rst = 1'h0;
		chk_val(16'({apply_w, release_w}), 16'h0000);
		ret = 1'h1;
		wait_clk(50);
		ret = 1'h0;
		wait_clk(CYC + 100);
		chk_flag(saw_inc | saw_hold, 1'h0);
		$display("test reset clears reference done");
		close_out();
	end
endmodule : tb
